// *** dual_timer_pkg.sv ***
// constants and types for the dual down-counting timer
`default_nettype none
package dual_timer_pkg;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned CNT_W      = 16;
  localparam int unsigned PRSC_W     = 5;
  localparam int unsigned CSEL_W     = 3;
  localparam int unsigned IDX_W      = 24;
  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CNT_ONE  = 24'hFFFF40;
  localparam logic [IDX_W-1:0] IDX_RELOAD_A = 24'hFFFF42;
  localparam logic [IDX_W-1:0] IDX_RELOAD_B = 24'hFFFF44;
  localparam logic [IDX_W-1:0] IDX_CNT_TWO  = 24'hFFFF46;
  localparam logic [IDX_W-1:0] IDX_PRSC     = 24'hFFFF48;
  localparam logic [IDX_W-1:0] IDX_CKSEL    = 24'hFFFF4A;
  localparam logic [IDX_W-1:0] IDX_MODE     = 24'hFFFF4C;
  localparam logic [IDX_W-1:0] IDX_IRQ_CTL  = 24'hFFFF4E;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLR  = 24'hFFFF50;
  localparam logic [15:0]      PRESET_VAL   = 16'hFFFF;
  localparam logic [15:0]      CNT_ZERO     = 16'h0000;
  localparam logic [15:0]      CNT_ONE      = 16'h0001;
  localparam logic [4:0]       PRSC_RESET   = 5'h00;
  localparam logic [4:0]       DIV_STEP     = 5'h01;
  localparam logic [5:0]       CKSEL_RESET  = 6'h00;
  localparam int unsigned      C1_LSB       = 0;
  localparam int unsigned      C2_LSB       = 3;
  // operating mode encodings
  localparam logic [1:0] MODE_PWM     = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_DUAL    = 2'h2;
  localparam logic [1:0] MODE_SINGLE  = 2'h3;
  // clock select encodings
  localparam logic [2:0] CSEL_NONE    = 3'h0;
  localparam logic [2:0] CSEL_PRESCL  = 3'h1;
  localparam logic [2:0] CSEL_EVENT   = 3'h2;
  localparam logic [2:0] CSEL_ACCUM   = 3'h3;
  localparam logic [2:0] CSEL_SLOW    = 3'h4;
  // pending / enable bit positions
  localparam int unsigned PND_A = 0;
  localparam int unsigned PND_B = 1;
  localparam int unsigned PND_C = 2;
  localparam int unsigned PND_D = 3;

  typedef struct packed {
    logic       ten;
    logic       pin_one_out_level;
    logic       pin_two_enable;
    logic       pin_one_enable;
    logic       pin_two_edge_polarity;
    logic       pin_one_edge_polarity;
    logic [1:0] operating_mode_field;
  } mode_ctrl_t;

  typedef struct packed {
    logic [3:0] ien;
    logic [3:0] pnd;
  } irq_ctrl_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [DATA_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_t;
endpackage
`default_nettype wire

// *** dual_timer.sv ***
// dual 16-bit down counter timer with pin functions and apb registers
`default_nettype none
module dual_timer (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst_b,
  // apb register bus
  input  wire dual_timer_pkg::apb_req_t apb_req,
  output var  logic [31:0]              prdata,
  output var  logic                     pready,
  output var  logic                     pslverr,
  // timer pins and slow clock
  input  wire logic                     pin_one_in,
  output var  logic                     pin_one_out,
  output var  logic                     pin_one_oe,
  input  wire logic                     timer_pin_two,
  input  wire logic                     slow_clk,
  // system timer interrupts
  output var  logic                     timer_irq_one,
  output var  logic                     timer_irq_two
);
  import dual_timer_pkg::*;

  function automatic logic reg_hit(input logic [DATA_W-1:0] a,
                                   input logic [IDX_W-1:0]  idx);
    return a == {6'h00, idx, 2'h0};
  endfunction

  function automatic logic edge_hit(input logic prev,
                                    input logic cur,
                                    input logic rising);
    return rising ? (cur & ~prev) : (prev & ~cur);
  endfunction

  // external sources only exist where pin two is not a capture input
  function automatic logic sel_tick(input logic [2:0] csel,
                                    input logic       ext_ok,
                                    input logic       pre,
                                    input logic       slow,
                                    input logic       ev,
                                    input logic       gate);
    logic t;
    t = 1'b0;
    case (csel)
      CSEL_PRESCL: t = pre;
      CSEL_EVENT:  t = ext_ok & ev;
      CSEL_ACCUM:  t = ext_ok & pre & gate;
      CSEL_SLOW:   t = slow;
      default:     t = 1'b0;
    endcase
    return t;
  endfunction

  mode_ctrl_t        ctl_q;
  mode_ctrl_t        ctl_d;
  irq_ctrl_t         irq_q;
  irq_ctrl_t         irq_d;
  logic [4:0]        prescale_value_q;
  logic [5:0]        ckc_q;
  logic [15:0]       counter_one_q;
  logic [15:0]       counter_two_q;
  logic [15:0]       reload_register_a_q;
  logic [15:0]       reload_register_b_q;
  logic [4:0]        div_q;
  logic              pin_one_prev_q;
  logic              pin_two_prev_q;
  logic              slow_prev_q;
  logic              pwm_phase_q;
  logic              acc_first;
  logic              wr_go;
  logic              mapped;
  logic [DATA_W-1:0] rd_d;
  logic              wr_cnt1;
  logic              wr_cnt2;
  logic              wr_rla;
  logic              wr_rlb;
  logic              wr_prsc;
  logic              wr_ckc;
  logic              wr_ctl;
  logic              wr_ictl;
  logic              wr_iclr;
  logic              m_pwm;
  logic              m_cap;
  logic              m_dual;
  logic              m_single;
  logic              ext_ok;
  logic              pre_tick;
  logic              slow_tick;
  logic              ta_edge;
  logic              tb_edge;
  logic              tb_gate;
  logic              tick1;
  logic              tick2;
  logic              uf1;
  logic              uf2;
  logic              cap_a;
  logic              cap_b1;
  logic              cap_b2;
  logic              rel_a1;
  logic              rel_b1;
  logic [3:0]        pnd_set;

  // bus decode: two-cycle access so every answer comes from a flop
  assign acc_first = apb_req.psel & apb_req.penable & ~pready;
  assign wr_go     = apb_req.psel & apb_req.penable & pready &
                     apb_req.pwrite;
  // counting registers are frozen while the timer is disabled
  assign wr_cnt1 = wr_go & ctl_q.ten & reg_hit(apb_req.paddr, IDX_CNT_ONE);
  assign wr_cnt2 = wr_go & ctl_q.ten & reg_hit(apb_req.paddr, IDX_CNT_TWO);
  assign wr_rla  = wr_go & ctl_q.ten & reg_hit(apb_req.paddr, IDX_RELOAD_A);
  assign wr_rlb  = wr_go & ctl_q.ten & reg_hit(apb_req.paddr, IDX_RELOAD_B);
  assign wr_prsc = wr_go & reg_hit(apb_req.paddr, IDX_PRSC);
  assign wr_ckc  = wr_go & reg_hit(apb_req.paddr, IDX_CKSEL);
  assign wr_ctl  = wr_go & reg_hit(apb_req.paddr, IDX_MODE);
  assign wr_ictl = wr_go & reg_hit(apb_req.paddr, IDX_IRQ_CTL);
  assign wr_iclr = wr_go & reg_hit(apb_req.paddr, IDX_IRQ_CLR);

  always_comb
  begin
    mapped = 1'b1;
    rd_d   = '0;
    if (reg_hit(apb_req.paddr, IDX_CNT_ONE))
      rd_d[CNT_W-1:0] = counter_one_q;
    else if (reg_hit(apb_req.paddr, IDX_RELOAD_A))
      rd_d[CNT_W-1:0] = reload_register_a_q;
    else if (reg_hit(apb_req.paddr, IDX_RELOAD_B))
      rd_d[CNT_W-1:0] = reload_register_b_q;
    else if (reg_hit(apb_req.paddr, IDX_CNT_TWO))
      rd_d[CNT_W-1:0] = counter_two_q;
    else if (reg_hit(apb_req.paddr, IDX_PRSC))
      rd_d[PRSC_W-1:0] = prescale_value_q;
    else if (reg_hit(apb_req.paddr, IDX_CKSEL))
      rd_d[5:0] = ckc_q;
    else if (reg_hit(apb_req.paddr, IDX_MODE))
      rd_d[7:0] = ctl_q;
    else if (reg_hit(apb_req.paddr, IDX_IRQ_CTL))
      rd_d[7:0] = irq_q;
    else if (!reg_hit(apb_req.paddr, IDX_IRQ_CLR))
      mapped = 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= acc_first;
      pslverr <= acc_first & ~mapped;
      if (acc_first)
        prdata <= (apb_req.pwrite || !mapped) ? '0 : rd_d;
    end
  end

  // mode and clock sources
  assign m_pwm    = ctl_q.operating_mode_field == MODE_PWM;
  assign m_cap    = ctl_q.operating_mode_field == MODE_CAPTURE;
  assign m_dual   = ctl_q.operating_mode_field == MODE_DUAL;
  assign m_single = ctl_q.operating_mode_field == MODE_SINGLE;
  assign ext_ok   = m_pwm | m_dual;

  assign pre_tick  = ctl_q.ten & (div_q >= prescale_value_q);
  assign slow_tick = ctl_q.ten & slow_clk & ~slow_prev_q;
  assign ta_edge   = ctl_q.ten & edge_hit(pin_one_prev_q, pin_one_in,
                                          ctl_q.pin_one_edge_polarity);
  assign tb_edge   = ctl_q.ten & edge_hit(pin_two_prev_q, timer_pin_two,
                                          ctl_q.pin_two_edge_polarity);
  assign tb_gate   = timer_pin_two == ctl_q.pin_two_edge_polarity;

  // a counter runs only with ten set and a select of 1 to 4; selects 2 and 3 also need ext_ok
  assign tick1 = sel_tick(ckc_q[C1_LSB +: CSEL_W], ext_ok, pre_tick,
                          slow_tick, tb_edge, tb_gate);
  assign tick2 = sel_tick(ckc_q[C2_LSB +: CSEL_W], ext_ok, pre_tick,
                          slow_tick, tb_edge, tb_gate);
  assign uf1 = tick1 & (counter_one_q == CNT_ZERO);
  assign uf2 = tick2 & (counter_two_q == CNT_ZERO);

  assign cap_a  = m_cap & ta_edge;
  assign cap_b1 = m_cap & tb_edge;
  assign cap_b2 = m_single & tb_edge;
  // pwm mode alternates the two reload values
  assign rel_a1 = uf1 & (m_dual | m_single | (m_pwm & ~pwm_phase_q));
  assign rel_b1 = uf1 & m_pwm & pwm_phase_q;

  assign pnd_set[PND_A] = rel_a1 | cap_a;
  assign pnd_set[PND_B] = rel_b1 | cap_b1 | cap_b2;
  assign pnd_set[PND_C] = m_cap & uf1;
  assign pnd_set[PND_D] = uf2;

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      div_q          <= PRSC_RESET;
      pin_one_prev_q <= 1'b0;
      pin_two_prev_q <= 1'b0;
      slow_prev_q    <= 1'b0;
    end
    else
    begin
      div_q          <= (!ctl_q.ten || pre_tick) ? PRSC_RESET
                        : div_q + DIV_STEP;
      pin_one_prev_q <= pin_one_in;
      pin_two_prev_q <= timer_pin_two;
      slow_prev_q    <= slow_clk;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      prescale_value_q <= PRSC_RESET;
      ckc_q            <= CKSEL_RESET;
    end
    else
    begin
      if (wr_prsc)
        prescale_value_q <= apb_req.pwdata[PRSC_W-1:0];
      if (wr_ckc)
        ckc_q <= apb_req.pwdata[5:0];
    end
  end

  // counter one: software write, capture preset, reload, count
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      counter_one_q <= CNT_ZERO;
    else if (wr_cnt1)
      counter_one_q <= apb_req.pwdata[CNT_W-1:0];
    else if ((cap_a && ctl_q.pin_one_enable) ||
             (cap_b1 && ctl_q.pin_two_enable))
      counter_one_q <= PRESET_VAL;
    else if (rel_a1)
      counter_one_q <= reload_register_a_q;
    else if (rel_b1)
      counter_one_q <= reload_register_b_q;
    else if (tick1)
      counter_one_q <= counter_one_q - CNT_ONE;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      counter_two_q <= CNT_ZERO;
    else if (wr_cnt2)
      counter_two_q <= apb_req.pwdata[CNT_W-1:0];
    else if (cap_b2 && ctl_q.pin_two_enable)
      counter_two_q <= PRESET_VAL;
    else if (uf2 && m_dual)
      counter_two_q <= reload_register_b_q;
    else if (tick2)
      counter_two_q <= counter_two_q - CNT_ONE;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      reload_register_a_q <= CNT_ZERO;
      reload_register_b_q <= CNT_ZERO;
    end
    else
    begin
      if (wr_rla)
        reload_register_a_q <= apb_req.pwdata[CNT_W-1:0];
      else if (cap_a)
        reload_register_a_q <= counter_one_q;
      if (wr_rlb)
        reload_register_b_q <= apb_req.pwdata[CNT_W-1:0];
      else if (cap_b1)
        reload_register_b_q <= counter_one_q;
      else if (cap_b2)
        reload_register_b_q <= counter_two_q;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b || !ctl_q.ten)
      pwm_phase_q <= 1'b0;
    else if (uf1 && m_pwm)
      pwm_phase_q <= ~pwm_phase_q;
  end

  // software write to the level bit beats the hardware toggle
  always_comb
  begin
    ctl_d = ctl_q;
    if (wr_ctl)
      ctl_d = apb_req.pwdata[7:0];
    else if (uf1 && ctl_q.pin_one_enable && !m_cap)
      ctl_d.pin_one_out_level = ~ctl_q.pin_one_out_level;
  end

  // hardware set wins over a clear in the same cycle
  always_comb
  begin
    irq_d = irq_q;
    if (wr_ictl)
    begin
      irq_d.ien = apb_req.pwdata[7:4];
      irq_d.pnd = irq_q.pnd | apb_req.pwdata[3:0];
    end
    if (wr_iclr)
      irq_d.pnd = irq_d.pnd & ~apb_req.pwdata[3:0];
    irq_d.pnd = irq_d.pnd | pnd_set;
    if (!ctl_q.ten)
      irq_d.pnd = '0;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      ctl_q         <= '0;
      irq_q         <= '0;
      pin_one_out   <= 1'b0;
      pin_one_oe    <= 1'b0;
      timer_irq_one <= 1'b0;
      timer_irq_two <= 1'b0;
    end
    else
    begin
      ctl_q         <= ctl_d;
      irq_q         <= irq_d;
      pin_one_out   <= ctl_d.pin_one_out_level;
      pin_one_oe    <= ctl_d.ten & ctl_d.pin_one_enable &
                       (ctl_d.operating_mode_field != MODE_CAPTURE);
      timer_irq_one <= |(irq_d.pnd[PND_C:PND_A] &
                         irq_d.ien[PND_C:PND_A]);
      timer_irq_two <= irq_d.pnd[PND_D] & irq_d.ien[PND_D];
    end
  end

  chk_pin_toggles: assert property (
    @(posedge mclk) disable iff (!rst_b)
    uf1 && ctl_q.pin_one_enable && !m_cap && !wr_ctl
    |=> pin_one_out != $past(pin_one_out))
    else $error("pin one did not toggle on underflow");

  chk_no_toggle_capture: assert property (
    @(posedge mclk) disable iff (!rst_b)
    m_cap && !wr_ctl |=> $stable(ctl_q.pin_one_out_level) && !pin_one_oe)
    else $error("pin one driven in capture mode");

  chk_capture_one: assert property (
    @(posedge mclk) disable iff (!rst_b)
    cap_a && !wr_rla |=> reload_register_a_q == $past(counter_one_q))
    else $error("pin one capture lost");

  chk_capture_preset: assert property (
    @(posedge mclk) disable iff (!rst_b)
    cap_a && ctl_q.pin_one_enable && !wr_cnt1
    |=> counter_one_q == PRESET_VAL)
    else $error("counter one not preset after capture");

  chk_capture_two: assert property (
    @(posedge mclk) disable iff (!rst_b)
    cap_b2 && !wr_rlb |=> reload_register_b_q == $past(counter_two_q))
    else $error("pin two capture lost");

  chk_flag_c_mode: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !m_cap && !wr_ictl && !irq_q.pnd[PND_C]
    |=> !irq_q.pnd[PND_C])
    else $error("flag c set outside mode two");

  chk_flag_d_set: assert property (
    @(posedge mclk) disable iff (!rst_b)
    uf2 && ctl_q.ten |=> irq_q.pnd[PND_D] ##1 1'b1)
    else $error("flag d missed underflow");

  chk_clock_stopped: assert property (
    @(posedge mclk) disable iff (!rst_b)
    ckc_q[C1_LSB +: CSEL_W] == CSEL_NONE && !wr_cnt1 && !cap_a && !cap_b1
    |=> $stable(counter_one_q))
    else $error("counter one moved without clock");

  chk_divide_one: assert property (
    @(posedge mclk) disable iff (!rst_b)
    ctl_q.ten && prescale_value_q == PRSC_RESET && !wr_prsc &&
    $past(ctl_q.ten) |-> pre_tick)
    else $error("divisor one must tick every cycle");

  chk_reset_clear: assert property (
    @(posedge mclk)
    !rst_b |=> ckc_q == CKSEL_RESET && prescale_value_q == PRSC_RESET)
    else $error("reset left clock settings set");

  chk_irq_two_map: assert property (
    @(posedge mclk) disable iff (!rst_b)
    timer_irq_two == (irq_q.pnd[PND_D] & irq_q.ien[PND_D]))
    else $error("interrupt two mapping wrong");

endmodule // dual_timer
`default_nettype wire

// *** pin_partner.sv ***
// far-side model of the two timer pins and the slow clock source
`default_nettype none
module pin_partner (
  // clock
  input  wire logic mclk,
  // timer side of the pins
  input  wire logic pin_one_out,
  input  wire logic pin_one_oe,
  output wire logic pin_one_in,
  output var  logic timer_pin_two,
  output var  logic slow_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       drv_one;
  logic [1:0] div_q;
  initial
  begin
    drv_one = 1'b0;
    timer_pin_two = 1'b0;
    slow_clk = 1'b0;
    div_q = 2'h0;
  end
  // pin one reads back the timer's own level while it drives the pin
  assign pin_one_in = pin_one_oe ? pin_one_out : drv_one;
  always @(posedge mclk)
  begin
    div_q <= div_q + 2'h1;
    if (div_q == 2'h3) slow_clk <= ~slow_clk;
  end
  // pulses stay high two cycles, above the one-cycle minimum width
  task automatic pulse(input int pin, input int n);
    repeat (n)
    begin
      @(posedge mclk);
      if (pin == 1) drv_one <= 1'b1; else timer_pin_two <= 1'b1;
      repeat (2) @(posedge mclk);
      if (pin == 1) drv_one <= 1'b0; else timer_pin_two <= 1'b0;
      repeat (2) @(posedge mclk);
    end
  endtask
endmodule // pin_partner
`default_nettype wire

// *** dual_timer_tb.sv ***
// self-checking bench for the dual timer over apb and its pins
`default_nettype none
module dual_timer_tb;
  import dual_timer_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk;
  logic        rst_b;
  apb_req_t    req;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  wire logic   pin_one_in;
  logic        pin_one_out;
  logic        pin_one_oe;
  logic        timer_pin_two;
  logic        slow_clk;
  logic        timer_irq_one;
  logic        timer_irq_two;
  logic [31:0] rdata;
  logic        rerr;
  logic [15:0] v1;
  int          rcyc;
  int          cyc_n;
  int          mismatches;
  int          check_count;
  int          n;

  dual_timer u_dut (
    .mclk(mclk), .rst_b(rst_b), .apb_req(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_one_in(pin_one_in),
    .pin_one_out(pin_one_out), .pin_one_oe(pin_one_oe),
    .timer_pin_two(timer_pin_two), .slow_clk(slow_clk),
    .timer_irq_one(timer_irq_one), .timer_irq_two(timer_irq_two)
  );
  pin_partner u_pins (
    .mclk(mclk), .pin_one_out(pin_one_out), .pin_one_oe(pin_one_oe),
    .pin_one_in(pin_one_in), .timer_pin_two(timer_pin_two),
    .slow_clk(slow_clk)
  );

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) cyc_n <= cyc_n + 1;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [23:0] idx,
                     input logic [31:0] wd);
    @(posedge mclk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= {6'h00, idx, 2'b00};
    req.pwdata  <= wd;
    @(posedge mclk);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rdata = prdata;
    rerr  = pslverr;
    rcyc  = cyc_n;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    if (n == 20)
    begin
      mismatches++;
      tally_and_finish();
    end
  endtask

  task automatic wait_pin(input logic lv);
    n = 0;
    while (pin_one_out !== lv && n < 50)
    begin
      @(posedge mclk);
      n++;
    end
    if (n == 50)
    begin
      mismatches++;
      tally_and_finish();
    end
  endtask

  task automatic test_regs();
    apb(0, IDX_PRSC, 0);
    check("prescaler reset", rdata, 0);
    apb(0, IDX_CKSEL, 0);
    check("clock select reset", rdata, 0);
    apb(0, 24'h000010, 0);
    check("unmapped error", {31'h0, rerr}, 1);
    apb(1, IDX_PRSC, 32'hFF);
    apb(0, IDX_PRSC, 0);
    check("prescaler width", rdata, 32'h1F);
    apb(1, IDX_CKSEL, 32'hCC);
    apb(0, IDX_CKSEL, 0);
    check("clock select fields", rdata, 32'h0C);
    apb(1, IDX_CKSEL, 0);
    $display("test regs done");
  endtask

  task automatic test_toggle();
    apb(1, IDX_PRSC, 0);
    apb(1, IDX_MODE, 32'h90);
    apb(1, IDX_RELOAD_A, 4);
    apb(1, IDX_RELOAD_B, 4);
    apb(1, IDX_CNT_ONE, 2);
    check("pin start level", {pin_one_oe, pin_one_out}, 2);
    apb(1, IDX_CKSEL, 32'h01);
    wait_pin(1);
    wait_pin(0);
    check("half period", n, 5);
    apb(0, IDX_IRQ_CTL, 0);
    check("mode one flags", rdata[3:0], 4'h3);
    apb(1, IDX_CKSEL, 0);
    apb(1, IDX_MODE, 32'hD0);
    repeat (2) @(posedge mclk);
    check("software level", pin_one_out, 1);
    apb(1, IDX_MODE, 0);
    $display("test toggle done");
  endtask

  task automatic test_prescale();
    int t0;
    apb(1, IDX_MODE, 32'h82);
    apb(1, IDX_PRSC, 3);
    apb(1, IDX_CNT_ONE, 32'h1000);
    apb(1, IDX_CKSEL, 32'h01);
    apb(0, IDX_CNT_ONE, 0);
    v1 = rdata[15:0];
    t0 = rcyc;
    repeat (37) @(posedge mclk);
    apb(0, IDX_CNT_ONE, 0);
    t0 = rcyc - t0;
    v1 = v1 - rdata[15:0];
    check("divide by four", v1 == t0 / 4 || v1 == t0 / 4 + 1, 1);
    apb(1, IDX_CKSEL, 0);
    $display("test prescale done");
  endtask

  task automatic test_event();
    apb(1, IDX_MODE, 32'h8A);
    apb(1, IDX_CNT_ONE, 32'h0100);
    apb(1, IDX_CKSEL, 32'h02);
    u_pins.pulse(2, 5);
    apb(0, IDX_CNT_ONE, 0);
    check("event count", rdata, 32'h00FB);
    apb(1, IDX_MODE, 32'h89);
    apb(1, IDX_CNT_ONE, 32'h0100);
    u_pins.pulse(2, 3);
    apb(0, IDX_CNT_ONE, 0);
    check("event refused", rdata, 32'h0100);
    apb(0, IDX_RELOAD_B, 0);
    check("pin two capture", rdata, 32'h0100);
    apb(0, IDX_IRQ_CTL, 0);
    check("flag b capture", rdata[1], 1);
    $display("test event done");
  endtask

  task automatic test_capture();
    apb(1, IDX_CKSEL, 0);
    apb(1, IDX_MODE, 32'h85);
    apb(1, IDX_CNT_ONE, 32'h1234);
    check("pin one input", pin_one_oe, 0);
    u_pins.pulse(1, 1);
    apb(0, IDX_RELOAD_A, 0);
    check("capture a", rdata, 32'h1234);
    apb(0, IDX_CNT_ONE, 0);
    check("no preset", rdata, 32'h1234);
    apb(0, IDX_IRQ_CTL, 0);
    check("flag a capture", rdata[0], 1);
    apb(1, IDX_MODE, 32'h95);
    apb(1, IDX_CNT_ONE, 32'h0042);
    u_pins.pulse(1, 1);
    apb(0, IDX_RELOAD_A, 0);
    check("capture a preset", rdata, 32'h0042);
    apb(0, IDX_CNT_ONE, 0);
    check("preset one", rdata, 32'hFFFF);
    apb(1, IDX_MODE, 32'hA9);
    apb(1, IDX_CNT_ONE, 32'h0077);
    u_pins.pulse(2, 1);
    apb(0, IDX_RELOAD_B, 0);
    check("capture b", rdata, 32'h0077);
    apb(0, IDX_CNT_ONE, 0);
    check("preset by pin two", rdata, 32'hFFFF);
    apb(1, IDX_MODE, 32'hAB);
    apb(1, IDX_PRSC, 31);
    apb(1, IDX_CNT_TWO, 32'h0055);
    apb(1, IDX_CKSEL, 32'h08);
    u_pins.pulse(2, 1);
    apb(0, IDX_RELOAD_B, 0);
    check("capture two", rdata > 32'h4F && rdata < 32'h56, 1);
    apb(0, IDX_CNT_TWO, 0);
    check("preset two", rdata > 32'hFFF0, 1);
    apb(1, IDX_CKSEL, 0);
    apb(1, IDX_MODE, 0);
    $display("test capture done");
  endtask

  task automatic test_irq();
    apb(1, IDX_MODE, 32'h80);
    apb(1, IDX_IRQ_CTL, 32'h88);
    repeat (2) @(posedge mclk);
    check("irq d only", {timer_irq_one, timer_irq_two}, 1);
    apb(1, IDX_IRQ_CLR, 32'h08);
    repeat (2) @(posedge mclk);
    check("irq d cleared", timer_irq_two, 0);
    apb(1, IDX_IRQ_CTL, 32'h74);
    repeat (2) @(posedge mclk);
    check("irq c maps one", {timer_irq_one, timer_irq_two}, 2);
    apb(1, IDX_IRQ_CLR, 32'h04);
    repeat (2) @(posedge mclk);
    check("irq one cleared", timer_irq_one, 0);
    $display("test irq done");
  endtask

  task automatic test_sources();
    int t0;
    apb(1, IDX_MODE, 0);
    apb(1, IDX_PRSC, 0);
    apb(1, IDX_MODE, 32'h8A);
    apb(1, IDX_CNT_ONE, 32'h0100);
    apb(1, IDX_CKSEL, 32'h03);
    repeat (8) @(posedge mclk);
    apb(0, IDX_CNT_ONE, 0);
    check("accumulate gated", rdata, 32'h0100);
    u_pins.pulse(2, 1);
    apb(0, IDX_CNT_ONE, 0);
    check("accumulate count", rdata, 32'h00FE);
    apb(1, IDX_CKSEL, 32'h04);
    apb(0, IDX_CNT_ONE, 0);
    v1 = rdata[15:0];
    t0 = rcyc;
    repeat (80) @(posedge mclk);
    apb(0, IDX_CNT_ONE, 0);
    t0 = rcyc - t0;
    v1 = v1 - rdata[15:0];
    check("slow clock rate", v1 == t0 / 8 || v1 == t0 / 8 + 1, 1);
    apb(1, IDX_CKSEL, 0);
    apb(1, IDX_IRQ_CLR, 32'h0F);
    apb(1, IDX_RELOAD_B, 2);
    apb(1, IDX_CNT_TWO, 0);
    apb(1, IDX_CKSEL, 32'h08);
    apb(0, IDX_CNT_TWO, 0);
    check("two reloads from b", rdata < 3, 1);
    apb(0, IDX_IRQ_CTL, 0);
    check("mode three flags", rdata[3:0], 4'h8);
    apb(1, IDX_CKSEL, 0);
    apb(1, IDX_MODE, 32'h81);
    apb(1, IDX_CNT_ONE, 32'h0001);
    apb(1, IDX_IRQ_CLR, 32'h0F);
    apb(1, IDX_CKSEL, 32'h01);
    apb(0, IDX_IRQ_CTL, 0);
    check("mode two flags", rdata[3:0], 4'h4);
    apb(0, IDX_CNT_ONE, 0);
    check("mode two wraps", rdata > 32'hFFF0, 1);
    apb(1, IDX_CKSEL, 0);
    apb(1, IDX_MODE, 0);
    $display("test sources done");
  endtask

  initial
  begin
    rst_b = 1'b0;
    req = '0;
    cyc_n = 0;
    mismatches = 0;
    check_count = 0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    test_regs();
    test_toggle();
    test_prescale();
    test_event();
    test_capture();
    test_irq();
    test_sources();
    tally_and_finish();
  end
endmodule // dual_timer_tb
`default_nettype wire
